// ---- common/fsr_pkg.sv ----
/*
  Constants, register map and state type for the fan speed readback block.
  Assumes a 10 MHz system clock and tachometer inputs synchronous to it.
*/
package fsr_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ   = 10_000_000;
  localparam int unsigned REF_HZ   = 100_000;
  localparam int unsigned TICK_DIV = CLK_HZ / REF_HZ;
  localparam logic [6:0]  TICK_LAST = 7'(TICK_DIV - 1);
  localparam logic [6:0]  TICK_ZERO = 7'h00;
  localparam logic [6:0]  TICK_ONE  = 7'h01;

  // ==========================================================
  // Register map (byte offsets)
  localparam logic [7:0] ADDR_APPLIED_DUTY_CYCLE = 8'h51;
  localparam logic [7:0] ADDR_FAN1_PERIOD_HIGH   = 8'h52;
  localparam logic [7:0] ADDR_FAN1_PERIOD_LOW    = 8'h53;
  localparam logic [7:0] ADDR_FAN2_PERIOD_HIGH   = 8'h54;
  localparam logic [7:0] ADDR_FAN2_PERIOD_LOW    = 8'h55;
  localparam logic [7:0] REG_RESET               = 8'h00;
  localparam logic [7:0] REG_UNMAPPED            = 8'h00;

  // ==========================================================
  // Period count layout
  localparam int unsigned COUNT_W   = 16;
  localparam int unsigned HIGH_LSB  = 8;
  localparam logic [15:0] COUNT_MAX  = 16'hFFFF;
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_ONE  = 16'h0001;

  // ==========================================================
  // Period measurement state
  typedef enum logic [0:0] {
    FSR_WAIT_EDGE = 1'b0,
    FSR_MEASURE   = 1'b1
  } fsr_meas_t;

endpackage

// ---- design/fsr_tach_period.sv ----
/*
  Period meter for one tachometer input, counted in reference ticks.
  Assumes tick_i is a one-cycle pulse at the reference rate and tach_i
  is synchronous to clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_tach_period (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  // Time base and fan input
  input  wire logic                        tick_i,
  input  wire logic                        tach_i,
  // Last measured period
  output logic [fsr_pkg::COUNT_W-1:0]      period_o
);
  import fsr_pkg::*;

  fsr_meas_t    state_r;
  fsr_meas_t    state_nxt;
  logic         tach_q_r;
  logic         rise;
  logic [15:0]  count_r;
  logic [15:0]  count_nxt;
  logic [15:0]  period_r;
  logic [15:0]  period_nxt;

  // ==========================================================
  // Next-state: tick counter between rising edges
  assign rise = tach_i & ~tach_q_r;

  always_comb begin
    state_nxt  = state_r;
    count_nxt  = count_r;
    period_nxt = period_r;
    case (state_r)
      FSR_WAIT_EDGE: begin
        // First edge only starts the count
        if (rise) begin
          state_nxt = FSR_MEASURE;
          // Count a tick on the start edge, as later edges do
          count_nxt = tick_i ? COUNT_ONE : COUNT_ZERO;
        end
      end
      FSR_MEASURE: begin
        if (rise) begin
          period_nxt = count_r;
          count_nxt  = tick_i ? COUNT_ONE : COUNT_ZERO;
        end else if (count_r == COUNT_MAX) begin
          period_nxt = COUNT_MAX; // Stalled fan reads full scale
        end else if (tick_i) begin
          count_nxt = count_r + COUNT_ONE;
        end
      end
      default: state_nxt = FSR_WAIT_EDGE;
    endcase
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      state_r  <= FSR_WAIT_EDGE;
      tach_q_r <= 1'b0;
      count_r  <= COUNT_ZERO;
      period_r <= COUNT_ZERO;
    end else begin
      state_r  <= state_nxt;
      tach_q_r <= tach_i;
      count_r  <= count_nxt;
      period_r <= period_nxt;
    end
  end

  assign period_o = period_r;

  // ==========================================================
  // Checks
  a_period_capture: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (rise && state_r == FSR_MEASURE) |=> (period_r == $past(count_r)))
    else $error("period not captured from tick count on edge");

endmodule
`default_nettype wire

// ---- design/fsr_readback.sv ----
/*
  Fan speed readback: applied duty register and two tachometer period
  counts, read by the host over a simple byte read port.
  Assumes duty_applied_i is the duty actually driven to the fan and all
  inputs are synchronous to the 10 MHz clock.
*/
// What this block does
// - Mirror applied fan duty, even during failure
// - Show fan one period count bits fifteen-eight
// - Show fan one period count bits seven-zero
// - Show fan two period count bits fifteen-eight
// - Count periods in 100 kHz reference ticks
// - Show fan two period count bits seven-zero
`timescale 1ns/1ps
`default_nettype none
module fsr_readback (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Fan side
  input  wire logic [7:0]  duty_applied_i,
  input  wire logic        fan1_speed_pulse_input_i,
  input  wire logic        fan2_speed_pulse_input_i,
  // Host register read port
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_addr_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rvalid_o
);
  import fsr_pkg::*;

  logic [6:0]   div_r;
  logic [6:0]   div_nxt;
  logic         tick;
  logic [15:0]  fan1_period;
  logic [15:0]  fan2_period;
  logic [7:0]   applied_duty_cycle_r;
  logic [7:0]   fan1_shadow_low_r;
  logic [7:0]   fan1_shadow_low_nxt;
  logic [7:0]   fan2_shadow_low_r;
  logic [7:0]   fan2_shadow_low_nxt;
  logic         fan1_lock_r;
  logic         fan1_lock_nxt;
  logic         fan2_lock_r;
  logic         fan2_lock_nxt;
  logic [7:0]   rdata_r;
  logic [7:0]   rdata_nxt;
  logic         rvalid_r;
  logic         rvalid_nxt;

  // ==========================================================
  // Reference time base
  // Divider yields a one-cycle tick at the reference rate
  always_comb begin
    div_nxt = (div_r == TICK_LAST) ? TICK_ZERO : div_r + TICK_ONE;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      div_r <= TICK_ZERO;
    end else begin
      div_r <= div_nxt;
    end
  end

  assign tick = (div_r == TICK_LAST);

  // ==========================================================
  // Period meters
  fsr_tach_period u_fan1 (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .tick_i   (tick),
    .tach_i   (fan1_speed_pulse_input_i),
    .period_o (fan1_period)
  );

  fsr_tach_period u_fan2 (
    .clk_i    (clk_i),
    .rstn_i   (rstn_i),
    .tick_i   (tick),
    .tach_i   (fan2_speed_pulse_input_i),
    .period_o (fan2_period)
  );

  // ==========================================================
  // Applied duty mirror, sampled every cycle with no gating
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      applied_duty_cycle_r <= REG_RESET;
    end else begin
      applied_duty_cycle_r <= duty_applied_i;
    end
  end

  // ==========================================================
  // Register read decode
  // High byte read freezes the matching low byte until it is read
  always_comb begin
    rdata_nxt           = rdata_r;
    rvalid_nxt          = 1'b0;
    fan1_lock_nxt       = fan1_lock_r;
    fan2_lock_nxt       = fan2_lock_r;
    fan1_shadow_low_nxt = fan1_shadow_low_r;
    fan2_shadow_low_nxt = fan2_shadow_low_r;
    if (reg_rd_i) begin
      rvalid_nxt = 1'b1;
      case (reg_addr_i)
        ADDR_APPLIED_DUTY_CYCLE: begin
          rdata_nxt = applied_duty_cycle_r;
        end
        ADDR_FAN1_PERIOD_HIGH: begin
          rdata_nxt           = fan1_period[COUNT_W-1:HIGH_LSB];
          fan1_shadow_low_nxt = fan1_period[HIGH_LSB-1:0];
          fan1_lock_nxt       = 1'b1;
        end
        ADDR_FAN1_PERIOD_LOW: begin
          rdata_nxt     = fan1_lock_r ? fan1_shadow_low_r : fan1_period[HIGH_LSB-1:0];
          fan1_lock_nxt = 1'b0;
        end
        ADDR_FAN2_PERIOD_HIGH: begin
          rdata_nxt           = fan2_period[COUNT_W-1:HIGH_LSB];
          fan2_shadow_low_nxt = fan2_period[HIGH_LSB-1:0];
          fan2_lock_nxt       = 1'b1;
        end
        ADDR_FAN2_PERIOD_LOW: begin
          rdata_nxt     = fan2_lock_r ? fan2_shadow_low_r : fan2_period[HIGH_LSB-1:0];
          fan2_lock_nxt = 1'b0;
        end
        default: begin
          rdata_nxt = REG_UNMAPPED;
        end
      endcase
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rdata_r           <= REG_RESET;
      rvalid_r          <= 1'b0;
      fan1_lock_r       <= 1'b0;
      fan2_lock_r       <= 1'b0;
      fan1_shadow_low_r <= REG_RESET;
      fan2_shadow_low_r <= REG_RESET;
    end else begin
      rdata_r           <= rdata_nxt;
      rvalid_r          <= rvalid_nxt;
      fan1_lock_r       <= fan1_lock_nxt;
      fan2_lock_r       <= fan2_lock_nxt;
      fan1_shadow_low_r <= fan1_shadow_low_nxt;
      fan2_shadow_low_r <= fan2_shadow_low_nxt;
    end
  end

  assign reg_rdata_o  = rdata_r;
  assign reg_rvalid_o = rvalid_r;

  // ==========================================================
  // Checks
  // Helper: cycles since the last tick
  logic [7:0] gap_r;
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      gap_r <= 8'h00;
    end else begin
      gap_r <= tick ? 8'h00 : gap_r + 8'h01;
    end
  end

  a_tick_spacing: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (tick && $past(tick, 1) == 1'b0 && gap_r != 8'h00) |-> (gap_r == 8'(TICK_DIV - 1)))
    else $error("reference tick spacing wrong");

  a_duty_readback: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == ADDR_APPLIED_DUTY_CYCLE) |=>
      (reg_rvalid_o && reg_rdata_o == $past(duty_applied_i, 2)))
    else $error("duty readback does not match applied duty");

  a_fan1_high: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == ADDR_FAN1_PERIOD_HIGH) |=>
      (reg_rvalid_o && reg_rdata_o == $past(fan1_period[15:8])))
    else $error("fan one high byte wrong");

  a_fan1_low_live: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == ADDR_FAN1_PERIOD_LOW && !fan1_lock_r) |=>
      (reg_rvalid_o && reg_rdata_o == $past(fan1_period[7:0])))
    else $error("fan one low byte wrong");

  a_fan2_high: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == ADDR_FAN2_PERIOD_HIGH) |=>
      (reg_rvalid_o && reg_rdata_o == $past(fan2_period[15:8])))
    else $error("fan two high byte wrong");

  a_fan2_low_live: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == ADDR_FAN2_PERIOD_LOW && !fan2_lock_r) |=>
      (reg_rvalid_o && reg_rdata_o == $past(fan2_period[7:0])))
    else $error("fan two low byte wrong");

  a_pair_coherent: assert property (
    @(posedge clk_i) disable iff (!rstn_i)
    (reg_rd_i && reg_addr_i == ADDR_FAN1_PERIOD_HIGH)
      ##1 (!reg_rd_i)[*1]
      ##1 (reg_rd_i && reg_addr_i == ADDR_FAN1_PERIOD_LOW) |=>
      (reg_rdata_o == $past(fan1_period[7:0], 3)))
    else $error("fan one byte pair split across measurements");

endmodule
`default_nettype wire

// ---- bench/fsr_fan_model.sv ----
/*
  Two fan tachometers: each gives a 10-cycle high pulse every period.
  Assumes period inputs in clk_i cycles; zero means a stopped fan.
*/
`timescale 1ns/1ps
`default_nettype none
module fsr_fan_model (
  // Clock
  input  wire logic        clk_i,
  // Pulse spacing in clock cycles
  input  wire logic [15:0] per1_i,
  input  wire logic [15:0] per2_i,
  // Tachometer outputs
  output logic             fan1_speed_pulse_input_o,
  output logic             fan2_speed_pulse_input_o
);
  // ==========================================================
  // Pulse generators
  logic [15:0] cnt1_r;
  logic [15:0] cnt2_r;
  // A stopped fan holds its line low, as the open-collector pull-down
  always_ff @(posedge clk_i) begin
    cnt1_r  <= (per1_i == 16'h0000 || cnt1_r >= per1_i - 16'h0001) ? 16'h0000 : cnt1_r + 16'h0001;
    cnt2_r  <= (per2_i == 16'h0000 || cnt2_r >= per2_i - 16'h0001) ? 16'h0000 : cnt2_r + 16'h0001;
    fan1_speed_pulse_input_o <= (per1_i != 16'h0000) && (cnt1_r < 16'h000A);
    fan2_speed_pulse_input_o <= (per2_i != 16'h0000) && (cnt2_r < 16'h000A);
  end
endmodule
`default_nettype wire

// ---- bench/fan_speed_readback_tb_top.sv ----
/*
  Testbench for the fan speed readback block.
  Assumes the one-cycle read answer and 100-cycle reference tick.
*/
`timescale 1ns/1ps
`default_nettype none
module fan_speed_readback_tb_top;
  import fsr_pkg::*;
  // ==========================================================
  // Signals
  logic       clk = 1'b0;
  logic       rstn = 1'b0;
  logic [7:0] duty = 8'h00;
  logic       rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] rdata;
  logic       rvalid;
  logic       t1;
  logic       t2;
  logic [15:0] per1 = 16'h0000;
  logic [15:0] per2 = 16'h0000;
  int         failures = 0;
  int         n_compared = 0;
  logic [7:0] got;

  // Clock of 100 ns
  initial begin
    forever #50 clk = ~clk;
  end

  // ==========================================================
  // Design and fan model
  fsr_readback i_dut (.clk_i(clk), .rstn_i(rstn), .duty_applied_i(duty), .fan1_speed_pulse_input_i(t1),
    .fan2_speed_pulse_input_i(t2), .reg_rd_i(rd), .reg_addr_i(addr), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid));
  fsr_fan_model i_fan (.clk_i(clk), .per1_i(per1), .per2_i(per2), .fan1_speed_pulse_input_o(t1), .fan2_speed_pulse_input_o(t2));

  // ==========================================================
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One read: request held one cycle, answer looked at in the next
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1 rd = 1'b1;
    addr = a;
    @(posedge clk) #1 rd = 1'b0;
    chk("read valid", {7'h00, rvalid}, 8'h01);
    d = rdata;
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    for (int a = 8'h51; a <= 8'h56; a++) begin
      rd_reg(8'(a), got);
      chk("reset value", got, 8'h00);
    end
    $display("test reset done");
  endtask

  // Duty mirrors the drive; each change read back before the next, extremes included
  task automatic t_duty();
    logic [7:0] v [4] = '{8'hA5, 8'hFF, 8'h00, 8'h5A};
    foreach (v[i]) begin
      @(posedge clk) #1 duty = v[i];
      rd_reg(ADDR_APPLIED_DUTY_CYCLE, got);
      chk("duty", got, v[i]);
    end
    $display("test duty done");
  endtask

  // Fan one 26000 cycles = 260 ticks (0104h), fan two 15000 = 150 (0096h)
  task automatic t_period();
    int n;
    per1 = 16'd26000;
    per2 = 16'd15000;
    got = 8'h00;
    for (n = 0; n < 700 && got !== 8'h01; n++) begin
      repeat (100) @(posedge clk);
      rd_reg(ADDR_FAN1_PERIOD_HIGH, got);
    end
    if (got !== 8'h01) begin
      failures++;
      $display("BAD period wait expected 01 seen %h", got);
      return;
    end
    rd_reg(ADDR_FAN1_PERIOD_HIGH, got);
    chk("fan1 high", got, 8'h01);
    rd_reg(ADDR_FAN1_PERIOD_LOW, got);
    chk("fan1 low", got, 8'h04);
    rd_reg(ADDR_FAN2_PERIOD_HIGH, got);
    chk("fan2 high", got, 8'h00);
    rd_reg(ADDR_FAN2_PERIOD_LOW, got);
    chk("fan2 low", got, 8'h96);
    rd_reg(8'hA0, got);
    chk("unmapped", got, REG_UNMAPPED);
    $display("test period done");
  endtask

  // Byte pair stays from one measurement while fan two speeds up to 5000 cycles
  task automatic t_coherent();
    rd_reg(ADDR_FAN2_PERIOD_HIGH, got);
    chk("fan2 high held", got, 8'h00);
    per2 = 16'd5000;
    repeat (12000) @(posedge clk);
    rd_reg(ADDR_FAN2_PERIOD_LOW, got);
    chk("fan2 low held", got, 8'h96);
    rd_reg(ADDR_FAN2_PERIOD_HIGH, got);
    chk("fan2 high new", got, 8'h00);
    rd_reg(ADDR_FAN2_PERIOD_LOW, got);
    chk("fan2 low new", got, 8'h32);
    $display("test coherent done");
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    t_reset();
    t_duty();
    t_period();
    t_coherent();
    give_verdict();
  end
endmodule
`default_nettype wire
